/* File: design/usb_port_pkg.sv */
package usb_port_pkg;
    // special function register addresses of the two port registers
    localparam logic [7:0] SFR_INDIRECT_ADDRESS_PORT = 8'h96;
    localparam logic [7:0] SFR_INDIRECT_DATA_PORT    = 8'h97;
    // address port fields
    localparam int         ADDR_BUSY_BIT   = 7;
    localparam int         ADDR_AUTO_READ_FLAG_BIT = 6;
    localparam logic [7:0] ADDR_PORT_RESET = 8'h00;
    localparam logic [7:0] DATA_PORT_RESET = 8'h00;
    // core register addresses
    localparam logic [5:0] CORE_FUNCTION_ADDRESS       = 6'h00;
    localparam logic [5:0] CORE_POWER_MANAGEMENT       = 6'h01;
    localparam logic [5:0] CORE_IN_INTERRUPT_FLAGS     = 6'h02;
    localparam logic [5:0] CORE_OUT_INTERRUPT_FLAGS    = 6'h04;
    localparam logic [5:0] CORE_COMMON_INTERRUPT_FLAGS = 6'h06;
    localparam logic [5:0] CORE_IN_INTERRUPT_ENABLES   = 6'h07;
    localparam logic [5:0] CORE_OUT_INTERRUPT_ENABLES  = 6'h09;
    localparam logic [5:0] CORE_COMMON_INTR_ENABLES    = 6'h0b;
    localparam logic [5:0] CORE_FRAME_NUMBER_LOW       = 6'h0c;
    localparam logic [5:0] CORE_FRAME_NUMBER_HIGH      = 6'h0d;
    localparam logic [5:0] CORE_ENDPOINT_INDEX_SELECT  = 6'h0e;
    localparam logic [5:0] CORE_CLOCK_RECOVERY_CONTROL = 6'h0f;
    localparam logic [5:0] CORE_EP0_CONTROL_STATUS     = 6'h11;
    localparam logic [5:0] CORE_EP_IN_CSR_HIGH         = 6'h12;
    localparam logic [5:0] CORE_EP_OUT_CSR_LOW         = 6'h14;
    localparam logic [5:0] CORE_EP_OUT_CSR_HIGH        = 6'h15;
    localparam logic [5:0] CORE_EP0_RECEIVED_COUNT     = 6'h16;
    localparam logic [5:0] CORE_EP_OUT_COUNT_HIGH      = 6'h17;
    localparam logic [5:0] CORE_ENDPOINT_ENABLE        = 6'h1e;
    localparam logic [5:0] CORE_FIFO_BASE              = 6'h20;
    localparam logic [5:0] CORE_FIFO_LAST              = 6'h23;
    // field values
    localparam logic [7:0] INDEX_WRITE_MASK    = 8'h0f;
    localparam logic [7:0] CLOCK_RECOVERY_CONTROL_RESET        = 8'h0f;
    localparam logic [7:0] REG_ZERO            = 8'h00;
    localparam int         SYNC_STAGES         = 3;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_REQ   = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DONE  = 4'b1000
    } xfer_state_t;
endpackage

/* File: design/usb_toggle_sync.sv */
`timescale 1ns/1ps
module usb_toggle_sync
    import usb_port_pkg::*;
(
    input  wire logic I_CLOCK,   // destination clock
    input  wire logic I_RESET_N, // async reset, active low
    input  wire logic i_toggle,  // toggle from the other domain
    output logic      o_pulse    // one-cycle pulse per change
);
    logic [SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], i_toggle};
        end
    end

    logic seen_q;
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            seen_q <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            seen_q <= stage_q[2];
        end
    end

    // change counts once the last two stages agree
    assign o_pulse = (stage_q[1] == stage_q[2]) && (stage_q[2] != seen_q);
endmodule

/* File: design/usb_core_regs.sv */
`timescale 1ns/1ps
module usb_core_regs
    import usb_port_pkg::*;
(
    input  wire logic       I_CLOCK,       // system clock
    input  wire logic       I_RESET_N,     // async reset, active low
    input  wire logic       i_wr,          // core register write
    input  wire logic       i_rd,          // core register read
    input  wire logic [5:0] i_addr,        // core register address
    input  wire logic [7:0] i_wdata,       // write data
    input  wire logic [7:0] i_fifo_rdata,  // byte popped from fifo
    input  wire logic [7:0] i_status [8],  // live status bytes
    output logic      [7:0] o_rdata,       // read data
    output logic      [7:0] o_index        // endpoint index
);
    logic [7:0] function_address_q, power_q, inie_q, outie_q, common_interrupt_enables_q, clock_recovery_control_q, een_q;
    logic [7:0] index_q;

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            function_address_q  <= REG_ZERO;
            power_q  <= REG_ZERO;
            inie_q   <= REG_ZERO;
            outie_q  <= REG_ZERO;
            common_interrupt_enables_q   <= REG_ZERO;
            clock_recovery_control_q <= CLOCK_RECOVERY_CONTROL_RESET;
            een_q    <= REG_ZERO;
            index_q  <= REG_ZERO;
        end else if (i_wr) begin
            case (i_addr)
                CORE_FUNCTION_ADDRESS:       function_address_q  <= i_wdata;
                CORE_POWER_MANAGEMENT:       power_q  <= i_wdata;
                CORE_IN_INTERRUPT_ENABLES:   inie_q   <= i_wdata;
                CORE_OUT_INTERRUPT_ENABLES:  outie_q  <= i_wdata;
                CORE_COMMON_INTR_ENABLES:    common_interrupt_enables_q   <= i_wdata;
                CORE_CLOCK_RECOVERY_CONTROL: clock_recovery_control_q <= i_wdata;
                CORE_ENDPOINT_ENABLE:        een_q    <= i_wdata;
                CORE_ENDPOINT_INDEX_SELECT:
                    index_q <= i_wdata & INDEX_WRITE_MASK;
                default: ;
            endcase
        end
    end

    assign o_index = index_q;

    always_comb begin
        o_rdata = REG_ZERO;
        case (i_addr)
            CORE_FUNCTION_ADDRESS:       o_rdata = function_address_q;
            CORE_POWER_MANAGEMENT:       o_rdata = power_q;
            CORE_IN_INTERRUPT_FLAGS:     o_rdata = i_status[0];
            CORE_OUT_INTERRUPT_FLAGS:    o_rdata = i_status[1];
            CORE_COMMON_INTERRUPT_FLAGS: o_rdata = i_status[2];
            CORE_IN_INTERRUPT_ENABLES:   o_rdata = inie_q;
            CORE_OUT_INTERRUPT_ENABLES:  o_rdata = outie_q;
            CORE_COMMON_INTR_ENABLES:    o_rdata = common_interrupt_enables_q;
            CORE_FRAME_NUMBER_LOW:       o_rdata = i_status[3];
            CORE_FRAME_NUMBER_HIGH:      o_rdata = i_status[4];
            CORE_ENDPOINT_INDEX_SELECT:  o_rdata = index_q;
            CORE_CLOCK_RECOVERY_CONTROL: o_rdata = clock_recovery_control_q;
            CORE_ENDPOINT_ENABLE:        o_rdata = een_q;
            CORE_EP0_CONTROL_STATUS,
            CORE_EP_IN_CSR_HIGH,
            CORE_EP_OUT_CSR_LOW,
            CORE_EP_OUT_CSR_HIGH:        o_rdata = i_status[5];
            CORE_EP0_RECEIVED_COUNT:     o_rdata = i_status[6];
            CORE_EP_OUT_COUNT_HIGH:      o_rdata = i_status[7];
            default: begin
                if (i_addr >= CORE_FIFO_BASE && i_addr <= CORE_FIFO_LAST) begin
                    o_rdata = i_fifo_rdata;
                end
            end
        endcase
    end

    logic unused_rd;
    assign unused_rd = i_rd;
endmodule

/* File: design/usb_indirect_register_port.sv */
// How it works
// - data port accesses go to the core register named by the select field
// - busy bit 7 reads 1 while an access runs, 0 when data is valid
// - with auto-read, reading the data port launches the next read
// - reads: load select and busy, wait busy low, read data
// - interrupt flags at 0x02, 0x04 and 0x06
// - interrupt enables at 0x07, 0x09 and 0x0b
// - function address 0x00, power 0x01, index select 0x0e
// - frame number low at 0x0c and high at 0x0d
// - clock recovery control at 0x0f
// - endpoint control/status registers at 0x11, 0x12, 0x14, 0x15
// - endpoint 0 received count at 0x16, out count high at 0x17
`timescale 1ns/1ps
module usb_indirect_register_port
    import usb_port_pkg::*;
#(
    parameter int NUM_FIFOS = 4
) (
    input  wire logic       I_CLOCK,         // system clock, 200 MHz
    input  wire logic       I_RESET_N,       // async reset, active low
    input  wire logic       I_SFR_WR,        // sfr write strobe
    input  wire logic       I_SFR_RD,        // sfr read strobe
    input  wire logic [7:0] I_SFR_ADDR,      // sfr address
    input  wire logic [7:0] I_SFR_WDATA,     // sfr write data
    output logic      [7:0] O_SFR_RDATA,     // sfr read data
    input  wire logic       I_CORE_ACK_TGL,  // core done toggle, usb clock
    input  wire logic [7:0] I_IN_FLAGS,      // in interrupt flags
    input  wire logic [7:0] I_OUT_FLAGS,     // out interrupt flags
    input  wire logic [7:0] I_COMMON_FLAGS,  // common interrupt flags
    input  wire logic [7:0] I_FRAME_LOW,     // frame number low
    input  wire logic [7:0] I_FRAME_HIGH,    // frame number high
    input  wire logic [7:0] I_EP_CSR,        // indexed csr byte
    input  wire logic [7:0] I_EP0_COUNT,     // endpoint 0 received count
    input  wire logic [7:0] I_OUT_COUNT_HI,  // out packet count high
    input  wire logic [7:0] I_FIFO_RDATA,    // byte from selected fifo
    output logic            O_CORE_REQ_TGL,  // request toggle to core
    output logic            O_CORE_WR,       // request is a write
    output logic      [5:0] O_CORE_ADDR,     // core register address
    output logic      [7:0] O_CORE_WDATA,    // core write data
    output logic            O_FIFO_PUSH,     // one byte into fifo
    output logic            O_FIFO_POP,      // one byte out of fifo
    output logic      [1:0] O_FIFO_SEL,      // fifo endpoint number
    output logic      [3:0] O_EP_INDEX       // endpoint index
);
    logic       busy_q;
    logic       auto_read_flag_q;
    logic [5:0] select_q;
    logic [7:0] data_q;
    logic       pend_wr_q;
    logic       req_tgl_q;
    logic [7:0] wdata_q;
    logic [5:0] xaddr_q;
    xfer_state_t state_q;

    logic addr_wr, data_wr, data_rd, ack_pulse, start_rd, start_wr;
    logic [7:0] core_rdata;
    logic [7:0] index;
    logic [7:0] status [8];

    assign addr_wr = I_SFR_WR && (I_SFR_ADDR == SFR_INDIRECT_ADDRESS_PORT);
    assign data_wr = I_SFR_WR && (I_SFR_ADDR == SFR_INDIRECT_DATA_PORT);
    assign data_rd = I_SFR_RD && (I_SFR_ADDR == SFR_INDIRECT_DATA_PORT);

    // read launched by busy write, or by data read with auto-read
    assign start_rd = (state_q == ST_IDLE) && !pend_wr_q &&
        ((addr_wr && I_SFR_WDATA[ADDR_BUSY_BIT]) ||
         (data_rd && auto_read_flag_q));
    assign start_wr = (state_q == ST_IDLE) && data_wr;

    usb_toggle_sync u_ack_sync (
        .I_CLOCK   (I_CLOCK),
        .I_RESET_N (I_RESET_N),
        .i_toggle  (I_CORE_ACK_TGL),
        .o_pulse   (ack_pulse)
    );

    // address port: select and auto-read fields, taken in one write
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            select_q <= ADDR_PORT_RESET[5:0];
            auto_read_flag_q <= ADDR_PORT_RESET[ADDR_AUTO_READ_FLAG_BIT];
        end else if (addr_wr) begin
            select_q <= I_SFR_WDATA[5:0];
            auto_read_flag_q <= I_SFR_WDATA[ADDR_AUTO_READ_FLAG_BIT];
        end
    end

    // transfer sequencer
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q   <= ST_IDLE;
            req_tgl_q <= 1'b0;
            pend_wr_q <= 1'b0;
            xaddr_q   <= ADDR_PORT_RESET[5:0];
            wdata_q   <= DATA_PORT_RESET;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_wr || start_rd) begin
                        // read launched by busy write takes the address newly given, else select
                        xaddr_q   <= addr_wr ? I_SFR_WDATA[5:0]
                                             : select_q;
                        pend_wr_q <= start_wr;
                        wdata_q   <= I_SFR_WDATA;
                        state_q   <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    req_tgl_q <= ~req_tgl_q;
                    state_q   <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (ack_pulse) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    pend_wr_q <= 1'b0;
                    state_q   <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // busy flag: high from launch until the access completes
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            busy_q <= ADDR_PORT_RESET[ADDR_BUSY_BIT];
        end else if (start_wr || start_rd) begin
            busy_q <= 1'b1;
        end else if (state_q == ST_DONE) begin
            busy_q <= 1'b0;
        end
    end

    // data port capture of the read result
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            data_q <= DATA_PORT_RESET;
        end else if (state_q == ST_DONE && !pend_wr_q) begin
            data_q <= core_rdata;
        end
    end

    assign status[0] = I_IN_FLAGS;
    assign status[1] = I_OUT_FLAGS;
    assign status[2] = I_COMMON_FLAGS;
    assign status[3] = I_FRAME_LOW;
    assign status[4] = I_FRAME_HIGH;
    assign status[5] = I_EP_CSR;
    assign status[6] = I_EP0_COUNT;
    assign status[7] = I_OUT_COUNT_HI;

    usb_core_regs u_regs (
        .I_CLOCK      (I_CLOCK),
        .I_RESET_N    (I_RESET_N),
        .i_wr         (ack_pulse && pend_wr_q),
        .i_rd         (ack_pulse && !pend_wr_q),
        .i_addr       (xaddr_q),
        .i_wdata      (wdata_q),
        .i_fifo_rdata (I_FIFO_RDATA),
        .i_status     (status),
        .o_rdata      (core_rdata),
        .o_index      (index)
    );

    logic in_fifo;
    assign in_fifo = (xaddr_q >= CORE_FIFO_BASE) &&
                     (xaddr_q <= CORE_FIFO_LAST);

    // fifo strobes fire once per completed access to a fifo address
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_FIFO_PUSH <= 1'b0;
            O_FIFO_POP  <= 1'b0;
        end else begin
            O_FIFO_PUSH <= ack_pulse && pend_wr_q && in_fifo;
            O_FIFO_POP  <= ack_pulse && !pend_wr_q && in_fifo;
        end
    end

    assign O_FIFO_SEL     = xaddr_q[1:0];
    assign O_CORE_REQ_TGL = req_tgl_q;
    assign O_CORE_WR      = pend_wr_q;
    assign O_CORE_ADDR    = xaddr_q;
    assign O_CORE_WDATA   = wdata_q;
    assign O_EP_INDEX     = index[3:0];

    always_comb begin
        O_SFR_RDATA = REG_ZERO;
        if (I_SFR_ADDR == SFR_INDIRECT_ADDRESS_PORT) begin
            O_SFR_RDATA = {busy_q, auto_read_flag_q, select_q};
        end else if (I_SFR_ADDR == SFR_INDIRECT_DATA_PORT) begin
            O_SFR_RDATA = data_q;
        end
    end

    logic unused_fifos;
    assign unused_fifos = (NUM_FIFOS == 0);
endmodule

/* File: tb/usb_port_assertions.sv */
`timescale 1ns/1ps
module usb_port_checker
    import usb_port_pkg::*;
#(
    parameter int NUM_FIFOS = 4
) (
    input wire logic       I_CLOCK,        // clock
    input wire logic       I_RESET_N,      // reset
    input wire logic       I_SFR_WR,       // sfr write
    input wire logic [7:0] I_SFR_ADDR,     // sfr address
    input wire logic [7:0] I_SFR_WDATA,    // sfr data
    input wire logic [7:0] O_SFR_RDATA,    // read data
    input wire logic       I_CORE_ACK_TGL, // core done
    input wire logic       O_CORE_REQ_TGL, // core request
    input wire logic       O_CORE_WR,      // request kind
    input wire logic [5:0] O_CORE_ADDR,    // core address
    input wire logic [7:0] O_CORE_WDATA,   // core data
    input wire logic       O_FIFO_PUSH,    // push pulse
    input wire logic       O_FIFO_POP,     // pop pulse
    input wire logic [1:0] O_FIFO_SEL,     // fifo number
    input wire logic [3:0] O_EP_INDEX      // endpoint index
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    sequence start_read_s;
        I_SFR_WR && I_SFR_ADDR == SFR_INDIRECT_ADDRESS_PORT &&
            I_SFR_WDATA[7] && !O_SFR_RDATA[7];
    endsequence
    sequence ack_polled_s;
        $changed(I_CORE_ACK_TGL) ##0
            (I_SFR_ADDR == SFR_INDIRECT_ADDRESS_PORT)[*7];
    endsequence
    req_launch_a: assert property (
        start_read_s |-> ##[1:3] $changed(O_CORE_REQ_TGL))
        else $error("read start gave no core request");
    req_hold_a: assert property (
        $changed(O_CORE_REQ_TGL) |=> $stable({O_CORE_REQ_TGL,
            O_CORE_WR, O_CORE_ADDR, O_CORE_WDATA})[*4])
        else $error("core request changed while busy");
    busy_clear_a: assert property (
        ack_polled_s |-> !O_SFR_RDATA[7])
        else $error("busy still set after core answer");
    pop_pulse_a: assert property (
        O_FIFO_POP |=> !O_FIFO_POP)
        else $error("pop pulse too long");
    push_pulse_a: assert property (
        $rose(O_FIFO_PUSH) |=> $fell(O_FIFO_PUSH))
        else $error("push pulse too long");
    fifo_map_a: assert property (
        (O_FIFO_PUSH || O_FIFO_POP) |-> O_FIFO_SEL == O_CORE_ADDR[1:0]
            && O_CORE_ADDR[5:2] == CORE_FIFO_BASE[5:2])
        else $error("fifo access outside fifo addresses");
    fifo_dir_a: assert property (
        (O_FIFO_PUSH || O_FIFO_POP) |-> O_CORE_WR == O_FIFO_PUSH)
        else $error("fifo direction differs from request");
    index_write_a: assert property (
        $changed(O_EP_INDEX) |-> O_CORE_WR &&
            O_CORE_ADDR == CORE_ENDPOINT_INDEX_SELECT)
        else $error("index moved without index write");
endmodule

/* File: tb/usb_core_model.sv */
`timescale 1ns/1ps
module usb_core_model (
    input  wire logic       i_clk,        // clock
    input  wire logic       i_rst_n,      // reset
    input  wire logic       i_req_tgl,    // request toggle
    input  wire logic       i_pop,        // fifo pop
    input  wire logic       i_slow,       // slow answer
    output logic            o_ack_tgl,    // done toggle
    output logic      [7:0] o_fifo_rdata  // fifo head byte
);
    logic       req_q;
    logic       pend_q;
    logic [4:0] wait_q;
    logic [7:0] pops_q;
    assign o_fifo_rdata = 8'hc0 + pops_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q     <= 1'b0;
            pend_q    <= 1'b0;
            wait_q    <= 5'h00;
            pops_q    <= 8'h00;
            o_ack_tgl <= 1'b0;
        end else begin
            req_q <= i_req_tgl;
            if (i_req_tgl != req_q) begin
                pend_q <= 1'b1;
                wait_q <= i_slow ? 5'h0c : 5'h00;
            end else if (pend_q && wait_q != 5'h00) begin
                wait_q <= wait_q - 5'h01;
            end else if (pend_q) begin
                pend_q    <= 1'b0;
                o_ack_tgl <= ~o_ack_tgl;
            end
            if (i_pop) begin
                pops_q <= pops_q + 8'h01;
            end
        end
    end
endmodule

/* File: tb/usb_indirect_register_port_tb.sv */
`timescale 1ns/1ps
module usb_indirect_register_port_tb
    import usb_port_pkg::*;
;
    localparam logic [7:0] adr = SFR_INDIRECT_ADDRESS_PORT;
    localparam logic [7:0] dat = SFR_INDIRECT_DATA_PORT;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       slow = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] st [8] = '{default: 8'h00};
    logic [5:0] sa [11] = '{6'h02, 6'h04, 6'h06, 6'h0c, 6'h0d, 6'h11,
                            6'h12, 6'h14, 6'h15, 6'h16, 6'h17};
    logic [5:0] ra [8] = '{6'h00, 6'h01, 6'h07, 6'h09, 6'h0b, 6'h0e,
                           6'h0f, 6'h1e};
    logic       ack, req, push, pop;
    logic [7:0] fdata;
    logic [3:0] ep_index;
    logic [7:0] cwdata;
    logic [7:0] last_push = 8'h00;
    logic [5:0] caddr;
    logic [1:0] fsel;
    int         mismatches = 0;
    int         num_checks = 0;
    int         pushes = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (push === 1'b1) begin
            pushes    <= pushes + 1;
            last_push <= cwdata;
        end
    end
    usb_indirect_register_port #(.NUM_FIFOS(4)) DUT (
        .I_CLOCK(clk), .I_RESET_N(rst_n), .I_SFR_WR(wr), .I_SFR_RD(rd),
        .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata),
        .I_CORE_ACK_TGL(ack), .I_IN_FLAGS(st[0]), .I_OUT_FLAGS(st[1]),
        .I_COMMON_FLAGS(st[2]), .I_FRAME_LOW(st[3]), .I_FRAME_HIGH(st[4]),
        .I_EP_CSR(st[5]), .I_EP0_COUNT(st[6]), .I_OUT_COUNT_HI(st[7]),
        .I_FIFO_RDATA(fdata), .O_CORE_REQ_TGL(req), .O_CORE_WR(),
        .O_CORE_ADDR(caddr), .O_CORE_WDATA(cwdata), .O_FIFO_PUSH(push),
        .O_FIFO_POP(pop), .O_FIFO_SEL(fsel), .O_EP_INDEX(ep_index));
    usb_core_model core (.i_clk(clk), .i_rst_n(rst_n), .i_req_tgl(req),
        .i_pop(pop), .i_slow(slow), .o_ack_tgl(ack), .o_fifo_rdata(fdata));
    function automatic logic [7:0] exp_status(input logic [5:0] a);
        case (a)
            6'h02: return st[0];
            6'h04: return st[1];
            6'h06: return st[2];
            6'h0c: return st[3];
            6'h0d: return st[4];
            6'h16: return st[6];
            6'h17: return st[7];
            default: return st[5];
        endcase
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    task automatic wait_idle();
        logic [7:0] v;
        for (int n = 0; n < 100; n++) begin
            sfr_read(adr, v);
            if (v[ADDR_BUSY_BIT] === 1'b0) return;
        end
        mismatches++;
        $display("mismatch at %0t: busy never cleared", $time);
        wrap_up();
    endtask
    task automatic core_read(input logic [5:0] a, output logic [7:0] d);
        wait_idle();
        sfr_write(adr, {2'b10, a});
        wait_idle();
        sfr_read(dat, d);
    endtask
    task automatic core_write(input logic [5:0] a, input logic [7:0] d);
        wait_idle();
        sfr_write(adr, {2'b00, a});
        sfr_write(dat, d);
    endtask
    initial begin
        logic [7:0] v;
        logic [7:0] w;
        logic [7:0] k;
        void'($urandom(16));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        sfr_read(adr, v);
        check(v, ADDR_PORT_RESET);
        sfr_read(8'h55, v);
        check(v, REG_ZERO);
        core_read(CORE_CLOCK_RECOVERY_CONTROL, v);
        check(v, CLOCK_RECOVERY_CONTROL_RESET);
        $display("reset test done");
        core_write(CORE_ENDPOINT_INDEX_SELECT, 8'h01);
        for (int i = 0; i < 11; i++) begin
            for (int j = 0; j < 8; j++) st[j] <= 8'($urandom);
            core_read(sa[i], v);
            check(v, exp_status(sa[i]));
            check({2'b00, caddr}, {2'b00, sa[i]});
        end
        $display("status map test done");
        for (int i = 0; i < 8; i++) begin
            w = 8'($urandom);
            if (ra[i] == CORE_ENDPOINT_INDEX_SELECT) w[3:2] = 2'b00;
            if (ra[i] == CORE_CLOCK_RECOVERY_CONTROL) w[4:0] = 5'h0f;
            core_write(ra[i], w ^ 8'h60);
            wait_idle();
            sfr_write(dat, w);
            core_read(ra[i], v);
            if (ra[i] == CORE_ENDPOINT_INDEX_SELECT) begin
                w = w & INDEX_WRITE_MASK;
                check({4'h0, ep_index}, w);
            end
            check(v, w);
        end
        $display("register test done");
        core_write(CORE_FUNCTION_ADDRESS, 8'h5a);
        wait_idle();
        slow <= 1'b1;
        sfr_write(adr, 8'h80);
        sfr_write(dat, 8'h33);
        wait_idle();
        sfr_read(dat, v);
        check(v, 8'h5a);
        slow <= 1'b0;
        $display("busy refusal test done");
        k = 8'h00;
        for (int e = 0; e < 4; e++) begin
            w = 8'($urandom);
            core_write(CORE_FIFO_BASE + 6'(e), w);
            wait_idle();
            check(8'(pushes), 8'(e + 1));
            check(last_push, w);
            check({6'h00, fsel}, 8'(e));
            slow <= e[0];
            sfr_write(adr, {2'b11, CORE_FIFO_BASE + 6'(e)});
            for (int r = 0; r < 3; r++) begin
                wait_idle();
                sfr_read(dat, v);
                check(v, 8'hc0 + k);
                k = k + 8'h01;
            end
            wait_idle();
            k = k + 8'h01;
            sfr_read(adr, v);
            check(v, {2'b01, CORE_FIFO_BASE + 6'(e)});
            sfr_write(adr, 8'h00);
        end
        $display("fifo test done");
        wrap_up();
    end
endmodule
bind usb_indirect_register_port usb_port_checker #(
    .NUM_FIFOS(NUM_FIFOS)
) chk (
    .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_SFR_WR(I_SFR_WR),
    .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WDATA(I_SFR_WDATA),
    .O_SFR_RDATA(O_SFR_RDATA), .I_CORE_ACK_TGL(I_CORE_ACK_TGL),
    .O_CORE_REQ_TGL(O_CORE_REQ_TGL), .O_CORE_WR(O_CORE_WR),
    .O_CORE_ADDR(O_CORE_ADDR), .O_CORE_WDATA(O_CORE_WDATA),
    .O_FIFO_PUSH(O_FIFO_PUSH), .O_FIFO_POP(O_FIFO_POP),
    .O_FIFO_SEL(O_FIFO_SEL), .O_EP_INDEX(O_EP_INDEX));
